// ===== core/pmw_pkg.sv
// constants, offsets and types for the power mode and wake-up controller
// Summary of operation
// - write-only four-bit threshold code, upper nibble, resets zero
// - bit 0 read-only reports supply below threshold; bits 3..1 reserved
// - exactly four states: running, power-save, power-down, wake delay
// - power-save gates core clock and program memory; oscillators keep their enables
// - program memory off in power-save and power-down
// - in power-save, timers on core clock or dead oscillator halt
// - pin toggle wakes only when direction and digital-input bits set
// - timer not on core clock wakes power-save at its match
// - comparator wake armed only when control bit 7 and select bit 6 set
// - power-down enters at once and stops every oscillator
// - data memory and registers held unchanged in power-down
// - power-down wakes only on pin toggle; timer, comparator power-save only
// - after wake, CPU resumes at next instruction, no reset
// - wake delay 3000 slow periods normal, 45 fast
package pmw_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] PMW_SUPPLY_DETECT_OFS = 8'h2D;
  localparam logic [7:0] PMW_MISC_OFS          = 8'h08;
  localparam logic [7:0] PMW_COMP_CTRL_OFS     = 8'h40;
  localparam logic [7:0] PMW_COMP_SEL_OFS      = 8'h41;
  localparam logic [7:0] PMW_WAKE_PIN_OFS      = 8'h42;
  localparam logic [7:0] PMW_TIMER_SRC_OFS     = 8'h43;
  localparam logic [7:0] PMW_OSC_EN_OFS        = 8'h44;
  localparam logic [7:0] PMW_IRQ_STAT_OFS      = 8'h45;
  localparam logic [7:0] PMW_IRQ_MASK_OFS      = 8'h46;
  localparam logic [7:0] PMW_MODE_OFS          = 8'h47;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int         PMW_LEVEL_LSB     = 4;
  localparam int         PMW_FAST_WAKE_BIT = 5;
  localparam int         PMW_COMP_EN_BIT   = 7;
  localparam int         PMW_COMP_WAKE_BIT = 6;
  localparam logic [3:0] PMW_LEVEL_RST     = 4'h0;
  localparam logic [1:0] PMW_OSC_EN_RST    = 2'h3;
  localparam int         PMW_NPINS         = 8;
  localparam int         PMW_NTIMERS       = 3;
  localparam int         PMW_NIRQ          = 4;

  // ------------------------------------------------------------
  // timing: slow oscillator tick divider and wake delays
  // ------------------------------------------------------------
  localparam int PMW_SLOW_PERIOD_NS = 17000;
  localparam int PMW_CLK_PERIOD_NS  = 5;
  localparam int PMW_SLOW_DIV       = PMW_SLOW_PERIOD_NS / PMW_CLK_PERIOD_NS;
  localparam int PMW_WAKE_NORMAL    = 3000;
  localparam int PMW_WAKE_FAST      = 45;

  typedef enum logic [1:0]
  {
    PMW_RUN   = 2'b00,
    PMW_SAVE  = 2'b01,
    PMW_DOWN  = 2'b10,
    PMW_DELAY = 2'b11
  } pmw_state_t;

endpackage

// ===== core/pmw_ctrl.sv
// power mode, wake-up and supply detect controller
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl
#(
  parameter int SLOW_DIV = pmw_pkg::PMW_SLOW_DIV
)
(
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // sleep instructions from cpu
  input  wire logic       save_cmd_in,
  input  wire logic       down_cmd_in,
  // wake sources
  input  wire logic [7:0] pins_in,
  input  wire logic [7:0] port_direction_bit_in,
  input  wire logic [7:0] port_digital_input_enable_in,
  input  wire logic [2:0] timer_match_in,
  input  wire logic       comp_event_in,
  input  wire logic       below_level_in,
  // power controls
  output logic            core_clock_en_out,
  output logic            fast_osc_en_out,
  output logic            slow_osc_en_out,
  output logic            program_memory_on_out,
  output logic [2:0]      timer_run_out,
  output logic            cpu_resume_out,
  output logic [3:0]      supply_level_out,
  output logic            irq_out
);

  // ------------------------------------------------------------
  // reset release and input synchronisers
  // ------------------------------------------------------------
  logic       rst_a_reg;
  logic       rst_reg;
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic [7:0] pin_prev_reg;
  logic [1:0] warm_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_a_reg <= 1'b0;
      rst_reg   <= 1'b0;
    end
    else
    begin
      rst_a_reg <= 1'b1;
      rst_reg   <= rst_a_reg;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      sync1_reg    <= 10'h000;
      sync2_reg    <= 10'h000;
      pin_prev_reg <= 8'h00;
      warm_reg     <= 2'h0;
    end
    else
    begin
      sync1_reg    <= {below_level_in, comp_event_in, pins_in};
      sync2_reg    <= sync1_reg;
      pin_prev_reg <= sync2_reg[7:0];
      // pins idling high would look like a toggle until the chain fills
      if (warm_reg != 2'h3)
        warm_reg <= warm_reg + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [3:0] level_reg;
  logic       fast_wake_reg;
  logic       comp_en_reg;
  logic       comp_wake_reg;
  logic [2:0] timer_slow_reg;
  logic [1:0] osc_en_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_set;
  pmw_pkg::pmw_state_t state_reg;

  always_ff @(posedge core_clk_in or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      level_reg      <= pmw_pkg::PMW_LEVEL_RST;
      fast_wake_reg  <= 1'b0;
      comp_en_reg    <= 1'b0;
      comp_wake_reg  <= 1'b0;
      timer_slow_reg <= 3'h0;
      osc_en_reg     <= pmw_pkg::PMW_OSC_EN_RST;
      irq_mask_reg   <= 4'h0;
    end
    else if (wr_in)
    begin
      case (addr_in)
        pmw_pkg::PMW_SUPPLY_DETECT_OFS:
          level_reg <= wdata_in[7:4];
        pmw_pkg::PMW_MISC_OFS:
          fast_wake_reg <= wdata_in[pmw_pkg::PMW_FAST_WAKE_BIT];
        pmw_pkg::PMW_COMP_CTRL_OFS:
          comp_en_reg <= wdata_in[pmw_pkg::PMW_COMP_EN_BIT];
        pmw_pkg::PMW_COMP_SEL_OFS:
          comp_wake_reg <= wdata_in[pmw_pkg::PMW_COMP_WAKE_BIT];
        pmw_pkg::PMW_TIMER_SRC_OFS:
          timer_slow_reg <= wdata_in[2:0];
        pmw_pkg::PMW_OSC_EN_OFS:
          osc_en_reg <= wdata_in[1:0];
        pmw_pkg::PMW_IRQ_MASK_OFS:
          irq_mask_reg <= wdata_in[3:0];
        default:
          irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // wake qualification
  // ------------------------------------------------------------
  logic [7:0] pin_wake;
  logic       any_pin;
  logic       timer_wake;
  logic       comp_wake;
  logic       tick;
  logic [11:0] delay_cnt_reg;
  logic [15:0] div_cnt_reg;

  genvar gi;
  generate
    for (gi = 0; gi < pmw_pkg::PMW_NPINS; gi++)
    begin : g_pin
      assign pin_wake[gi] = (sync2_reg[gi] ^ pin_prev_reg[gi]) &
                            (warm_reg == 2'h3) &
                            port_direction_bit_in[gi] &
                            port_digital_input_enable_in[gi];
    end
  endgenerate

  assign any_pin    = |pin_wake;
  // timer matches come from same-clock timer logic
  assign timer_wake = |(timer_match_in & timer_slow_reg & {3{osc_en_reg[1]}});
  assign comp_wake  = sync2_reg[8] & comp_en_reg & comp_wake_reg;
  assign tick       = (div_cnt_reg == 16'(SLOW_DIV - 1));

  // slow oscillator tick divider; stops when the oscillator is off
  always_ff @(posedge core_clk_in or negedge rst_reg)
  begin
    if (!rst_reg)
      div_cnt_reg <= 16'h0000;
    else if (tick || !slow_osc_en_out)
      div_cnt_reg <= 16'h0000;
    else
      div_cnt_reg <= div_cnt_reg + 16'h0001;
  end

  // ------------------------------------------------------------
  // mode state machine
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      state_reg     <= pmw_pkg::PMW_RUN;
      delay_cnt_reg <= 12'h000;
    end
    else
    begin
      case (state_reg)
        pmw_pkg::PMW_RUN:
          if (down_cmd_in)
            state_reg <= pmw_pkg::PMW_DOWN;
          else if (save_cmd_in)
            state_reg <= pmw_pkg::PMW_SAVE;
        pmw_pkg::PMW_SAVE:
          if (any_pin || timer_wake || comp_wake)
          begin
            state_reg     <= pmw_pkg::PMW_DELAY;
            delay_cnt_reg <= 12'h000;
          end
        pmw_pkg::PMW_DOWN:
          if (any_pin)
          begin
            state_reg     <= pmw_pkg::PMW_DELAY;
            delay_cnt_reg <= 12'h000;
          end
        pmw_pkg::PMW_DELAY:
          if (tick)
          begin
            if (delay_cnt_reg == (fast_wake_reg ?
                12'(pmw_pkg::PMW_WAKE_FAST - 1) :
                12'(pmw_pkg::PMW_WAKE_NORMAL - 1)))
              state_reg <= pmw_pkg::PMW_RUN;
            else
              delay_cnt_reg <= delay_cnt_reg + 12'h001;
          end
        default:
          state_reg <= pmw_pkg::PMW_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // power outputs; registers are never touched by sleep
  // ------------------------------------------------------------
  logic prev_delay_reg;

  always_ff @(posedge core_clk_in or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      core_clock_en_out     <= 1'b1;
      fast_osc_en_out       <= 1'b1;
      slow_osc_en_out       <= 1'b1;
      program_memory_on_out <= 1'b1;
      timer_run_out         <= 3'h7;
      cpu_resume_out        <= 1'b0;
      supply_level_out      <= pmw_pkg::PMW_LEVEL_RST;
      prev_delay_reg        <= 1'b0;
    end
    else
    begin
      prev_delay_reg        <= (state_reg == pmw_pkg::PMW_DELAY);
      core_clock_en_out     <= (state_reg == pmw_pkg::PMW_RUN);
      program_memory_on_out <= (state_reg == pmw_pkg::PMW_RUN);
      // power-down stops oscillators; the slow one restarts for the delay
      fast_osc_en_out <= osc_en_reg[0] &&
                         (state_reg == pmw_pkg::PMW_RUN ||
                          state_reg == pmw_pkg::PMW_SAVE);
      slow_osc_en_out <= (state_reg != pmw_pkg::PMW_DOWN) &&
                         (osc_en_reg[1] ||
                          state_reg == pmw_pkg::PMW_DELAY);
      timer_run_out   <= (state_reg == pmw_pkg::PMW_RUN) ? 3'h7 :
                         (state_reg == pmw_pkg::PMW_SAVE) ?
                         (timer_slow_reg & {3{osc_en_reg[1]}}) :
                         3'h0;
      cpu_resume_out  <= prev_delay_reg &&
                         (state_reg == pmw_pkg::PMW_RUN);
      supply_level_out <= level_reg;
    end
  end

  // ------------------------------------------------------------
  // interrupt status: set wins over write-one-to-clear
  // ------------------------------------------------------------
  assign irq_set = {comp_wake, timer_wake, any_pin, sync2_reg[9]};

  always_ff @(posedge core_clk_in or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      irq_stat_reg <= 4'h0;
      irq_out      <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= irq_set | (irq_stat_reg &
                      ~((wr_in && addr_in == pmw_pkg::PMW_IRQ_STAT_OFS) ?
                        wdata_in[3:0] : 4'h0));
      irq_out      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // read port; write-only fields read as zero
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_reg)
  begin
    if (!rst_reg)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        pmw_pkg::PMW_SUPPLY_DETECT_OFS:
          rdata_out <= {7'h00, sync2_reg[9]};
        pmw_pkg::PMW_TIMER_SRC_OFS:
          rdata_out <= {5'h00, timer_slow_reg};
        pmw_pkg::PMW_OSC_EN_OFS:
          rdata_out <= {6'h00, osc_en_reg};
        pmw_pkg::PMW_IRQ_STAT_OFS:
          rdata_out <= {4'h0, irq_stat_reg};
        pmw_pkg::PMW_IRQ_MASK_OFS:
          rdata_out <= {4'h0, irq_mask_reg};
        pmw_pkg::PMW_MODE_OFS:
          rdata_out <= {6'h00, state_reg};
        default:
          rdata_out <= 8'h00;
      endcase
    end
    else
      rdata_out <= 8'h00;
  end

endmodule // pmw_ctrl
`default_nettype wire

// ===== testbench/pmw_cpu_model.sv
// behavioural cpu that issues sleep instructions and resumes after wake
`timescale 1ns/10ps
`default_nettype none
module pmw_cpu_model
(
  // clock and wake handshake
  input  wire logic       clk_in,
  input  wire logic       slow_osc_en_in,
  input  wire logic       resume_in,
  // sleep instructions
  output logic            save_cmd_out,
  output logic            down_cmd_out,
  // count of instructions run after each wake
  output logic [7:0]      pc_out
);
  initial
  begin
    save_cmd_out = 1'b0;
    down_cmd_out = 1'b0;
    pc_out       = 8'h00;
  end

  // save is only issued with the slow oscillator left running
  task automatic sleep(input logic deep);
    @(posedge clk_in);
    if (deep)
      down_cmd_out <= 1'b1;
    else if (slow_osc_en_in)
      save_cmd_out <= 1'b1;
    @(posedge clk_in);
    save_cmd_out <= 1'b0;
    down_cmd_out <= 1'b0;
  endtask

  // program continues at the next instruction, no restart
  always @(posedge clk_in)
    if (resume_in)
      pc_out <= pc_out + 8'h01;
endmodule // pmw_cpu_model
`default_nettype wire

// ===== testbench/pmw_ctrl_chk.sv
// port assertions for the power mode and wake-up controller
`timescale 1ns/10ps
`default_nettype none
module pmw_ctrl_chk
#(
  parameter int SLOW_DIV = 4
)
(
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       save_cmd_in,
  input wire logic       down_cmd_in,
  input wire logic       core_clock_en_out,
  input wire logic       fast_osc_en_out,
  input wire logic       slow_osc_en_out,
  input wire logic       program_memory_on_out,
  input wire logic       cpu_resume_out,
  input wire logic [3:0] supply_level_out
);
  // one slow tick of slack for the divider phase
  localparam int MIN_SLP = (pmw_pkg::PMW_WAKE_FAST - 1) * SLOW_DIV;
  int   slp_cnt;
  logic lvl_wr;
  assign lvl_wr = wr_in && addr_in == pmw_pkg::PMW_SUPPLY_DETECT_OFS;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      slp_cnt <= 0;
    else
      slp_cnt <= core_clock_en_out ? 0 : slp_cnt + 1;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence run_save;
    save_cmd_in && !down_cmd_in && core_clock_en_out;
  endsequence
  sequence run_down;
    down_cmd_in && core_clock_en_out;
  endsequence
  sequence clock_back;
    !core_clock_en_out ##1 core_clock_en_out;
  endsequence

  a_save_gates_clk: assert property (run_save |-> ##2
    !core_clock_en_out && !program_memory_on_out) else $error("save gating");
  a_save_keeps_osc: assert property (run_save |-> ##2
    {fast_osc_en_out, slow_osc_en_out} ==
    $past({fast_osc_en_out, slow_osc_en_out}, 2)) else $error("osc changed");
  a_down_stops_osc: assert property (run_down |-> ##2
    !(fast_osc_en_out || slow_osc_en_out || program_memory_on_out))
    else $error("down not applied");
  a_wake_needs_resume: assert property (clock_back |->
    cpu_resume_out) else $error("clock back without resume");
  a_resume_one_cycle: assert property (cpu_resume_out |=>
    !cpu_resume_out) else $error("resume too long");
  a_wake_delay_min: assert property (cpu_resume_out |->
    slp_cnt >= MIN_SLP) else $error("wake too early");
  a_level_write: assert property (lvl_wr |=> ##1
    supply_level_out == $past(wdata_in[7:4], 2)) else $error("level write");
  a_level_hold: assert property (!lvl_wr |=> ##1
    $stable(supply_level_out)) else $error("level moved");
  a_detect_read: assert property (rd_in && addr_in == 8'h2D |=>
    rdata_out[7:1] == 7'h00) else $error("detect read bits");
  a_rdata_idle: assert property (!rd_in |=>
    rdata_out == 8'h00) else $error("rdata not idle");
endmodule // pmw_ctrl_chk
bind pmw_ctrl pmw_ctrl_chk #(.SLOW_DIV(SLOW_DIV)) i_pmw_ctrl_chk (
  .core_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .save_cmd_in, .down_cmd_in, .core_clock_en_out, .fast_osc_en_out,
  .slow_osc_en_out, .program_memory_on_out, .cpu_resume_out,
  .supply_level_out);
`default_nettype wire

// ===== testbench/pmw_ctrl_bench.sv
// self-checking bench for the power mode and wake-up controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module pmw_ctrl_bench;
  localparam int DIV = 4;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic comp_event_in = 1'b0, below_level_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, pins_in = 8'h00, rv;
  logic [7:0] port_direction_bit_in = 8'hFF;
  logic [7:0] port_digital_input_enable_in = 8'h00;
  logic [2:0] timer_match_in = 3'h0, timer_run_out;
  logic [7:0] rdata_out, pc;
  logic [3:0] supply_level_out;
  logic save_cmd_in, down_cmd_in, core_clock_en_out, fast_osc_en_out;
  logic slow_osc_en_out, program_memory_on_out, cpu_resume_out, irq_out;
  logic [31:0] seed = 32'h00006D48;
  logic [2:0] k;
  int err_count = 0, compares = 0, n;

  always #2.5 core_clk_in = ~core_clk_in;

  pmw_ctrl #(.SLOW_DIV(DIV)) i_pmw_ctrl (.core_clk_in, .rst_n_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .save_cmd_in, .down_cmd_in,
    .pins_in, .port_direction_bit_in, .port_digital_input_enable_in,
    .timer_match_in, .comp_event_in, .below_level_in, .core_clock_en_out,
    .fast_osc_en_out, .slow_osc_en_out, .program_memory_on_out,
    .timer_run_out, .cpu_resume_out, .supply_level_out, .irq_out);
  pmw_cpu_model i_pmw_cpu_model (.clk_in(core_clk_in),
    .slow_osc_en_in(slow_osc_en_out), .resume_in(cpu_resume_out),
    .save_cmd_out(save_cmd_in), .down_cmd_out(down_cmd_in), .pc_out(pc));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int wake_cycles(input logic fast);
    return DIV * (fast ? pmw_pkg::PMW_WAKE_FAST : pmw_pkg::PMW_WAKE_NORMAL);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_in);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  task automatic wait_wake(output int c);
    c = 0;
    while (cpu_resume_out !== 1'b1 && c < 20000)
    begin
      @(posedge core_clk_in);
      #1 c++;
    end
    `CHK(cpu_resume_out, 1'b1)
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    rd(8'h44, rv); `CHK(rv, 8'h03)
    rd(8'h77, rv); `CHK(rv, 8'h00)
    `CHK(supply_level_out, 4'h0)
    for (int i = 0; i < 16; i++)
    begin
      @(posedge core_clk_in) below_level_in <= 1'(xs());
      wr(8'h2D, {i[3:0], 4'(xs())});
      @(posedge core_clk_in);
      #1 `CHK(supply_level_out, i[3:0])
      rd(8'h2D, rv); `CHK(rv, {7'h00, below_level_in})
    end
    // power-save with fast wake, timer 0 on the slow oscillator
    wr(8'h08, 8'h20);
    wr(8'h43, 8'h01);
    wr(8'h46, 8'h0E);
    k = 3'(xs());
    i_pmw_cpu_model.sleep(1'b0);
    @(posedge core_clk_in);
    #1 `CHK({core_clock_en_out, program_memory_on_out}, 2'b00)
    `CHK({fast_osc_en_out, slow_osc_en_out}, 2'b11)
    `CHK(timer_run_out, 3'b001)
    // pin without digital input, unarmed comparator, core-clock timers
    @(posedge core_clk_in);
    pins_in <= pins_in ^ (8'h01 << k);
    {comp_event_in, timer_match_in} <= 4'hE;
    repeat (3) @(posedge core_clk_in);
    {comp_event_in, timer_match_in} <= 4'h0;
    repeat (60) @(posedge core_clk_in);
    #1 `CHK(core_clock_en_out, 1'b0)
    @(posedge core_clk_in) timer_match_in <= 3'b001;
    @(posedge core_clk_in) timer_match_in <= 3'b000;
    wait_wake(n);
    `CHK(n >= wake_cycles(1'b1) - DIV, 1'b1)
    `CHK(n <= wake_cycles(1'b1) + 2 * DIV + 8, 1'b1)
    @(posedge core_clk_in);
    #1 `CHK(pc, 8'h01)
    `CHK(irq_out, 1'b1)
    wr(8'h46, 8'h00);
    @(posedge core_clk_in);
    #1 `CHK(irq_out, 1'b0)
    wr(8'h46, 8'h0E);
    wr(8'h45, 8'h04);
    @(posedge core_clk_in);
    #1 `CHK(irq_out, 1'b0)
    // comparator wake once both arming bits are set
    wr(8'h40, 8'h80);
    wr(8'h41, 8'h40);
    i_pmw_cpu_model.sleep(1'b0);
    @(posedge core_clk_in) comp_event_in <= 1'b1;
    wait_wake(n);
    @(posedge core_clk_in) comp_event_in <= 1'b0;
    #1 `CHK(pc, 8'h02)
    // power-down with normal wake, only a digital pin may wake it
    wr(8'h08, 8'h00);
    @(posedge core_clk_in) port_digital_input_enable_in <= 8'h01 << k;
    i_pmw_cpu_model.sleep(1'b1);
    @(posedge core_clk_in);
    #1 `CHK({fast_osc_en_out, slow_osc_en_out}, 2'b00)
    `CHK({core_clock_en_out, program_memory_on_out}, 2'b00)
    @(posedge core_clk_in) {comp_event_in, timer_match_in} <= 4'hF;
    repeat (3) @(posedge core_clk_in);
    {comp_event_in, timer_match_in} <= 4'h0;
    repeat (60) @(posedge core_clk_in);
    #1 `CHK(core_clock_en_out, 1'b0)
    @(posedge core_clk_in) pins_in <= pins_in ^ (8'h01 << k);
    wait_wake(n);
    `CHK(n >= wake_cycles(1'b0) - DIV, 1'b1)
    `CHK(n <= wake_cycles(1'b0) + 2 * DIV + 8, 1'b1)
    @(posedge core_clk_in);
    #1 `CHK(pc, 8'h03)
    `CHK(supply_level_out, 4'hF)
    rd(8'h43, rv); `CHK(rv, 8'h01)
    rd(8'h47, rv); `CHK(rv, 8'h00)
    tally_and_finish();
  end
endmodule // pmw_ctrl_bench
`default_nettype wire
